// ===== core/pmsl_pkg.sv
// Constants shared by the motor speed loop block.
// Assumes all users reference names through pmsl_pkg::.
`default_nettype none
package pmsl_pkg;
   // ---------------------------------------------
   // Widths
   // ---------------------------------------------
   localparam int SPD_W = 16;
   localparam int TRQ_W = 13;
   localparam int ACC_W = 48;
   localparam int FILT_FRAC = 16;
   // ---------------------------------------------
   // Scaling and levels
   // ---------------------------------------------
   localparam logic [11:0] HW_OV_COUNTS = 12'hd20;  // 3360
   localparam logic [11:0] HW_UV_COUNTS = 12'h3d0;  // 976
   localparam int TRIP_SHIFT = 4;                   // Level register times 16
   localparam int MIN_SPD_SHIFT = 3;                // Min speed /2048 vs /16383
   localparam int SPD_SCL_SHIFT = 14;               // Feedback scale fraction bits
   localparam int PI_SHIFT = 12;                    // Regulator gain fraction bits
   localparam logic [11:0] ROOT_FIRST = 12'h800;    // Square root first trial bit
   // ---------------------------------------------
   // Fault word layout
   // ---------------------------------------------
   localparam int FW_W = 4;
   localparam int FW_SW = 0;
   localparam int FW_HW_OV = 1;
   localparam int FW_HW_UV = 2;
   localparam int FW_CRIT = 3;
   // ---------------------------------------------
   // State encodings
   // ---------------------------------------------
   typedef enum logic [1:0] {
      VQ_IDLE = 2'b00,
      VQ_ROOT = 2'b01,
      VQ_FILT = 2'b10
   } pmsl_vq_state_t;
   typedef enum logic [1:0] {
      GATE_RUN = 2'b00,
      GATE_OFF = 2'b01,
      GATE_ZERO = 2'b10
   } pmsl_gate_mode_t;
endpackage : pmsl_pkg
`default_nettype wire

// ===== core/pmsl_ramp.sv
// Speed reference ramp toward a signed target.
// Assumes tick_i is a one-cycle strobe per PWM period on sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module pmsl_ramp (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic tick_i,
   input wire logic signed [15:0] target_i,
   input wire logic [14:0] accel_step_i,
   input wire logic [14:0] decel_step_i,
   input wire logic [4:0] ramp_shift_i,
   output logic signed [15:0] speed_reference_o
);
   typedef struct packed {
      logic signed [pmsl_pkg::ACC_W-1:0] acc;
      logic signed [15:0] ref_q;
   } pmsl_ramp_t;
   pmsl_ramp_t r;
   pmsl_ramp_t next_r;
   // ---------------------------------------------
   // Ramp step
   // ---------------------------------------------
   // Accumulator keeps fraction bits below the shift point
   always_comb begin
      logic signed [pmsl_pkg::ACC_W-1:0] goal;
      logic signed [pmsl_pkg::ACC_W-1:0] diff;
      logic signed [pmsl_pkg::ACC_W-1:0] mag;
      logic signed [pmsl_pkg::ACC_W-1:0] step;
      logic up;
      logic away;
      goal = pmsl_pkg::ACC_W'(target_i) <<< ramp_shift_i;
      diff = goal - r.acc;
      up = diff > 0;
      mag = up ? diff : -diff;
      away = up ? (r.acc >= 0) : (r.acc <= 0);
      step = away ? pmsl_pkg::ACC_W'({1'b0, accel_step_i}) : pmsl_pkg::ACC_W'({1'b0, decel_step_i});
      next_r = r;
      if (tick_i) begin
         if (mag <= step) begin
            next_r.acc = goal;
         end else if (up) begin
            next_r.acc = r.acc + step;
         end else begin
            next_r.acc = r.acc - step;
         end
      end
      next_r.ref_q = 16'(next_r.acc >>> ramp_shift_i);
   end
   // State register
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
   assign speed_reference_o = r.ref_q;
endmodule : pmsl_ramp
`default_nettype wire

// ===== core/pmsl_vq_limit.sv
// Dynamic q-axis voltage ceiling: root of ceiling squared less vd squared.
// Assumes tick_i strobes once per PWM period; result settles in 14 cycles.
`timescale 1ns/1ps
`default_nettype none
module pmsl_vq_limit (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic tick_i,
   input wire logic [11:0] modulation_ceiling_i,
   input wire logic signed [12:0] vd_i,
   input wire logic [11:0] q_voltage_fixed_i,
   input wire logic [3:0] vq_filter_shift_i,
   output logic [11:0] q_voltage_ceiling_o
);
   typedef struct packed {
      pmsl_pkg::pmsl_vq_state_t st;
      logic [25:0] rad;
      logic [11:0] root;
      logic [11:0] mask;
      logic signed [28:0] filt;
      logic [11:0] lim;
   } pmsl_vq_t;
   pmsl_vq_t r;
   pmsl_vq_t next_r;
   // ---------------------------------------------
   // Root and filter sequencer
   // ---------------------------------------------
   always_comb begin
      logic [12:0] vd_mag;
      logic [25:0] m2;
      logic [25:0] d2;
      logic [11:0] trial;
      logic signed [28:0] goal;
      vd_mag = vd_i[12] ? 13'(-vd_i) : 13'(vd_i);
      m2 = 26'(modulation_ceiling_i * modulation_ceiling_i);
      d2 = 26'(vd_mag * vd_mag);
      trial = r.root | r.mask;
      goal = 29'(r.root) << pmsl_pkg::FILT_FRAC;
      next_r = r;
      case (r.st)
         pmsl_pkg::VQ_IDLE: begin
            if (tick_i) begin
               next_r.rad = (m2 > d2) ? (m2 - d2) : 26'h0000000;
               next_r.root = 12'h000;
               next_r.mask = pmsl_pkg::ROOT_FIRST;
               next_r.st = pmsl_pkg::VQ_ROOT;
            end
         end
         pmsl_pkg::VQ_ROOT: begin
            if (26'(trial * trial) <= r.rad) begin
               next_r.root = trial;
            end
            next_r.mask = r.mask >> 1;
            if (r.mask[0]) begin
               next_r.st = pmsl_pkg::VQ_FILT;
            end
         end
         pmsl_pkg::VQ_FILT: begin
            if (modulation_ceiling_i == 12'h000) begin
               next_r.filt = 29'(q_voltage_fixed_i) << pmsl_pkg::FILT_FRAC;
               next_r.lim = q_voltage_fixed_i;
            end else begin
               next_r.filt = r.filt + ((goal - r.filt) >>> vq_filter_shift_i);
               next_r.lim = next_r.filt[pmsl_pkg::FILT_FRAC +: 12];
            end
            next_r.st = pmsl_pkg::VQ_IDLE;
         end
         default: begin
            next_r.st = pmsl_pkg::VQ_IDLE;
         end
      endcase
   end
   // State register
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
   assign q_voltage_ceiling_o = r.lim;
endmodule : pmsl_vq_limit
`default_nettype wire

// ===== core/pmsl_speed_loop.sv
// Per-PWM-period speed loop, torque limit, bus protection and gate stage.
// Assumes pwm_tick_i is a one-cycle strobe from the PWM timer on sys_clk_i,
// and that the host writes all settings as steady levels.
// Only the overcurrent shutdown pin comes from outside the clock domain.
// Gate outputs are raw phase states; dead time is added further on.
`timescale 1ns/1ps
`default_nettype none
module pmsl_speed_loop (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic pwm_tick_i,
   input wire logic [13:0] speed_target_i,
   input wire logic rotation_direction_i,
   input wire logic [7:0] min_speed_i,
   input wire logic [14:0] accel_step_i,
   input wire logic [14:0] decel_step_i,
   input wire logic [4:0] ramp_shift_i,
   input wire logic [14:0] prop_gain_i,
   input wire logic [14:0] integ_gain_i,
   input wire logic [11:0] motor_limit_i,
   input wire logic [11:0] regen_limit_i,
   input wire logic signed [15:0] rotor_freq_i,
   input wire logic [15:0] speed_scale_i,
   input wire logic [11:0] modulation_ceiling_i,
   input wire logic [3:0] vq_filter_shift_i,
   input wire logic [11:0] q_voltage_fixed_i,
   input wire logic signed [12:0] vd_i,
   input wire logic [11:0] bus_voltage_counts_i,
   input wire logic [7:0] critical_level_i,
   input wire logic [7:0] ov_level_i,
   input wire logic [7:0] uv_level_i,
   input wire logic fault_clear_i,
   input wire logic hw_ov_disable_i,
   input wire logic hw_uv_disable_i,
   input wire logic gate_shutdown_input_i,
   input wire logic [11:0] duty_u_i,
   input wire logic [11:0] duty_v_i,
   input wire logic [11:0] duty_w_i,
   input wire logic [11:0] carrier_i,
   output logic signed [15:0] speed_reference_o,
   output logic signed [15:0] speed_feedback_o,
   output logic signed [12:0] torque_command_o,
   output logic [11:0] q_voltage_ceiling_o,
   output logic [3:0] fault_word_o,
   output logic overvoltage_flag_o,
   output logic undervoltage_flag_o,
   output logic bus_critical_flag_o,
   output logic ov_trip_o,
   output logic uv_trip_o,
   output logic crit_trip_o,
   output logic [2:0] gate_high_o,
   output logic [2:0] gate_low_o
);
   // All registered state of the block outside the ramp and ceiling instances
   typedef struct packed {
      logic sd_meta;
      logic sd_sync;
      logic signed [15:0] fbk;
      logic signed [39:0] integ;
      logic signed [12:0] trq;
      logic ov_trip;
      logic uv_trip;
      logic crit_trip;
      logic ov_flag;
      logic uv_flag;
      logic crit_flag;
      logic hw_ov;
      logic hw_uv;
      pmsl_pkg::pmsl_gate_mode_t mode;
      logic [2:0] g_hi;
      logic [2:0] g_lo;
   } pmsl_core_t;

   pmsl_core_t r;
   pmsl_core_t next_r;
   // Conditioned target and per-phase comparator results
   logic signed [15:0] signed_target;
   logic [2:0] phase_on;
   logic [35:0] duty_all;

   // ---------------------------------------------
   // Target conditioning
   // ---------------------------------------------
   // Raise small non-zero targets to the floor, then apply the sign
   // A zero target bypasses the floor so the motor can be stopped
   always_comb begin
      logic [13:0] floor_v;
      logic [13:0] mag;
      floor_v = 14'(min_speed_i) << pmsl_pkg::MIN_SPD_SHIFT;
      mag = speed_target_i;
      if (speed_target_i != 14'h0000 && speed_target_i < floor_v) begin
         mag = floor_v;
      end
      if (rotation_direction_i) begin
         signed_target = 16'({2'b00, mag});
      end else begin
         signed_target = -16'({2'b00, mag});
      end
   end

   // Speed reference ramp, stepped by the period strobe
   // Its output is registered, so the regulator sees a settled value
   pmsl_ramp u_ramp (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .tick_i(pwm_tick_i),
      .target_i(signed_target),
      .accel_step_i(accel_step_i),
      .decel_step_i(decel_step_i),
      .ramp_shift_i(ramp_shift_i),
      .speed_reference_o(speed_reference_o)
   );

   // Dynamic q-axis voltage ceiling
   // The ceiling lags each strobe by the root and filter steps
   pmsl_vq_limit u_vq (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .tick_i(pwm_tick_i),
      .modulation_ceiling_i(modulation_ceiling_i),
      .vd_i(vd_i),
      .q_voltage_fixed_i(q_voltage_fixed_i),
      .vq_filter_shift_i(vq_filter_shift_i),
      .q_voltage_ceiling_o(q_voltage_ceiling_o)
   );

   // ---------------------------------------------
   // Per-phase carrier comparators
   // ---------------------------------------------
   // A phase conducts high while its duty exceeds the carrier
   assign duty_all = {duty_w_i, duty_v_i, duty_u_i};
   for (genvar p = 0; p < 3; p++) begin : g_phase
      assign phase_on[p] = duty_all[p*12 +: 12] > carrier_i;
   end

   // ---------------------------------------------
   // Regulator, protection and gate state
   // ---------------------------------------------
   always_comb begin
      logic signed [32:0] fb_prod;
      logic signed [16:0] err;
      logic signed [39:0] p_term;
      logic signed [39:0] i_step;
      logic signed [39:0] out_full;
      logic signed [39:0] hi_lim;
      logic signed [39:0] lo_lim;
      logic [11:0] ov_lvl;
      logic [11:0] uv_lvl;
      logic [11:0] crit_lvl;
      logic sat_hi;
      logic sat_lo;
      // Feedback: rotor frequency times scale, fraction bits dropped
      fb_prod = 33'(rotor_freq_i) * 33'(signed'({1'b0, speed_scale_i}));
      err = 17'(speed_reference_o) - 17'(r.fbk);
      // Regulator terms keep the gain fraction until the final shift
      p_term = 40'(err) * 40'(signed'({1'b0, prop_gain_i}));
      i_step = 40'(err) * 40'(signed'({1'b0, integ_gain_i}));
      out_full = (p_term + r.integ) >>> pmsl_pkg::PI_SHIFT;
      // Clamp window: motor limit above, negated regen limit below
      hi_lim = 40'(signed'({1'b0, motor_limit_i}));
      lo_lim = -40'(signed'({1'b0, regen_limit_i}));
      sat_hi = out_full > hi_lim;
      sat_lo = out_full < lo_lim;
      // Software trip levels are the level settings times sixteen
      ov_lvl = 12'(ov_level_i) << pmsl_pkg::TRIP_SHIFT;
      uv_lvl = 12'(uv_level_i) << pmsl_pkg::TRIP_SHIFT;
      crit_lvl = 12'(critical_level_i) << pmsl_pkg::TRIP_SHIFT;
      next_r = r;
      // Overcurrent pin passes two flops before use
      next_r.sd_meta = gate_shutdown_input_i;
      next_r.sd_sync = r.sd_meta;
      // Period update: feedback, torque and software trips
      if (pwm_tick_i) begin
         next_r.fbk = 16'(fb_prod >>> pmsl_pkg::SPD_SCL_SHIFT);
         if (sat_hi) begin
            next_r.trq = 13'(hi_lim);
         end else if (sat_lo) begin
            next_r.trq = 13'(lo_lim);
         end else begin
            next_r.trq = 13'(out_full);
         end
         // Integrate only when not pushing further into the clamp
         // Unwinding stays allowed, so the output leaves the clamp at once
         if (!((sat_hi && err > 0) || (sat_lo && err < 0))) begin
            next_r.integ = r.integ + i_step;
         end
         next_r.ov_trip = bus_voltage_counts_i > ov_lvl;
         next_r.uv_trip = bus_voltage_counts_i < uv_lvl;
         next_r.crit_trip = bus_voltage_counts_i > crit_lvl;
      end
      // Latched flags: a trip wins over a clear in the same cycle
      // A held clear keeps the flags low between trips
      if (fault_clear_i) begin
         next_r.ov_flag = 1'b0;
         next_r.uv_flag = 1'b0;
         next_r.crit_flag = 1'b0;
         next_r.hw_ov = 1'b0;
         next_r.hw_uv = 1'b0;
      end
      if (pwm_tick_i && next_r.ov_trip) begin
         next_r.ov_flag = 1'b1;
      end
      if (pwm_tick_i && next_r.uv_trip) begin
         next_r.uv_flag = 1'b1;
      end
      if (pwm_tick_i && next_r.crit_trip) begin
         next_r.crit_flag = 1'b1;
      end
      // Hardware comparators act every clock, each with its own disable
      // They latch so a short bus spike still leaves a trace
      if (!hw_ov_disable_i && bus_voltage_counts_i > pmsl_pkg::HW_OV_COUNTS) begin
         next_r.hw_ov = 1'b1;
      end
      if (!hw_uv_disable_i && bus_voltage_counts_i < pmsl_pkg::HW_UV_COUNTS) begin
         next_r.hw_uv = 1'b1;
      end
      // Gate mode: critical first, then shutdown or any fault
      // The zero vector stops the motor charging the bus, even in shutdown
      if (next_r.crit_flag) begin
         next_r.mode = pmsl_pkg::GATE_ZERO;
      end else if (r.sd_sync || next_r.ov_flag || next_r.uv_flag || next_r.hw_ov || next_r.hw_uv) begin
         next_r.mode = pmsl_pkg::GATE_OFF;
      end else begin
         next_r.mode = pmsl_pkg::GATE_RUN;
      end
      // High and low sides of one phase are never on together
      case (next_r.mode)
         pmsl_pkg::GATE_ZERO: begin
            next_r.g_hi = 3'h0;
            next_r.g_lo = 3'h7;
         end
         pmsl_pkg::GATE_OFF: begin
            next_r.g_hi = 3'h0;
            next_r.g_lo = 3'h0;
         end
         pmsl_pkg::GATE_RUN: begin
            next_r.g_hi = phase_on;
            next_r.g_lo = ~phase_on;
         end
         // Unused mode code keeps every gate off
         default: begin
            next_r.g_hi = 3'h0;
            next_r.g_lo = 3'h0;
         end
      endcase
   end

   // State register
   // Reset leaves every gate off and every flag clear
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // ---------------------------------------------
   // Outputs
   // ---------------------------------------------
   // Registered data and flag outputs
   assign speed_feedback_o = r.fbk;
   assign torque_command_o = r.trq;
   assign overvoltage_flag_o = r.ov_flag;
   assign undervoltage_flag_o = r.uv_flag;
   assign bus_critical_flag_o = r.crit_flag;
   assign ov_trip_o = r.ov_trip;
   assign uv_trip_o = r.uv_trip;
   assign crit_trip_o = r.crit_trip;
   // Gate drive straight from the state register, free of glitches
   assign gate_high_o = r.g_hi;
   assign gate_low_o = r.g_lo;
   // Fault word: processor fault plus hardware and critical bits
   // Bit positions come from the package to keep one map
   always_comb begin
      fault_word_o = '0;
      fault_word_o[pmsl_pkg::FW_SW] = r.ov_flag | r.uv_flag;
      fault_word_o[pmsl_pkg::FW_HW_OV] = r.hw_ov;
      fault_word_o[pmsl_pkg::FW_HW_UV] = r.hw_uv;
      fault_word_o[pmsl_pkg::FW_CRIT] = r.crit_flag;
   end
endmodule : pmsl_speed_loop
`default_nettype wire

// ===== test/pmsl_speed_loop_checker.sv
// Checker for the speed loop block, watching its top-level ports only.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pmsl_speed_loop_checker (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic pwm_tick_i,
   input wire logic [11:0] bus_voltage_counts_i,
   input wire logic [7:0] ov_level_i,
   input wire logic hw_ov_disable_i,
   input wire logic hw_uv_disable_i,
   input wire logic fault_clear_i,
   input wire logic gate_shutdown_input_i,
   input wire logic [11:0] motor_limit_i,
   input wire logic signed [15:0] speed_reference_o,
   input wire logic signed [12:0] torque_command_o,
   input wire logic [3:0] fault_word_o,
   input wire logic overvoltage_flag_o,
   input wire logic undervoltage_flag_o,
   input wire logic bus_critical_flag_o,
   input wire logic ov_trip_o,
   input wire logic [2:0] gate_high_o,
   input wire logic [2:0] gate_low_o
);
   // ------------------------------
   // Port relations over time
   // ------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   AST_REF_HOLD:
   assert property (!pwm_tick_i |=> $stable(speed_reference_o)) else $error("reference moved off tick");
   AST_TRQ_LIM:
   assert property (pwm_tick_i |=> torque_command_o <= $signed({1'b0, $past(motor_limit_i)}))
      else $error("torque above motor limit");
   AST_OV_TRIP:
   assert property (pwm_tick_i |=> ov_trip_o == ($past(bus_voltage_counts_i) > {$past(ov_level_i), 4'h0}))
      else $error("over trip wrong");
   AST_OV_FLAG:
   assert property ($rose(ov_trip_o) |-> overvoltage_flag_o) else $error("over flag not set");
   AST_FW_MAP:
   assert property (fault_word_o[pmsl_pkg::FW_SW] == (overvoltage_flag_o || undervoltage_flag_o)
      && fault_word_o[pmsl_pkg::FW_CRIT] == bus_critical_flag_o) else $error("fault word map wrong");
   AST_HW_OV:
   assert property (bus_voltage_counts_i > pmsl_pkg::HW_OV_COUNTS && !hw_ov_disable_i
      |=> fault_word_o[pmsl_pkg::FW_HW_OV]) else $error("hw over not flagged");
   AST_HW_UV_OFF:
   assert property (hw_uv_disable_i && fault_clear_i |=> !fault_word_o[pmsl_pkg::FW_HW_UV])
      else $error("disabled hw under flagged");
   AST_SHUTDOWN:
   assert property (gate_shutdown_input_i [*4] ##0 !bus_critical_flag_o |-> gate_high_o == 3'h0
      && gate_low_o == 3'h0) else $error("gates on in shutdown");
   AST_CRIT_GATE:
   assert property (bus_critical_flag_o |-> gate_high_o == 3'h0 && gate_low_o == 3'h7)
      else $error("no zero vector");
   AST_NO_OVERLAP:
   assert property ((gate_high_o & gate_low_o) == 3'h0) else $error("both gates on");
endmodule : pmsl_speed_loop_checker
bind pmsl_speed_loop pmsl_speed_loop_checker u_chk (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
   .pwm_tick_i(pwm_tick_i), .bus_voltage_counts_i(bus_voltage_counts_i), .ov_level_i(ov_level_i),
   .hw_ov_disable_i(hw_ov_disable_i), .hw_uv_disable_i(hw_uv_disable_i), .fault_clear_i(fault_clear_i),
   .gate_shutdown_input_i(gate_shutdown_input_i), .motor_limit_i(motor_limit_i),
   .speed_reference_o(speed_reference_o), .torque_command_o(torque_command_o), .fault_word_o(fault_word_o),
   .overvoltage_flag_o(overvoltage_flag_o), .undervoltage_flag_o(undervoltage_flag_o),
   .bus_critical_flag_o(bus_critical_flag_o), .ov_trip_o(ov_trip_o), .gate_high_o(gate_high_o),
   .gate_low_o(gate_low_o));
`default_nettype wire

// ===== test/pmsl_host_model.sv
// Host controller model that writes speed settings and the fault clear.
// Assumes the bench calls its tasks from one thread.
`timescale 1ns/1ps
`default_nettype none
module pmsl_host_model (
   input wire logic sys_clk_i,
   output logic [13:0] speed_target_o,
   output logic rotation_direction_o,
   output logic [7:0] min_speed_o,
   output logic fault_clear_o
);
   // ------------------------------
   // Setting writes
   // ------------------------------
   // Settings are steady levels, changed just after an edge
   initial begin
      speed_target_o = 14'h0;
      rotation_direction_o = 1'b1;
      min_speed_o = 8'h0;
      fault_clear_o = 1'b0;
   end
   task automatic set_speed(input logic [13:0] t, input logic d, input logic [7:0] m);
      @(posedge sys_clk_i);
      #1;
      speed_target_o = t;
      rotation_direction_o = d;
      min_speed_o = m;
   endtask : set_speed
   // Clear held longer than one PWM period so a tick sees it
   task automatic clear_faults();
      @(posedge sys_clk_i);
      #1;
      fault_clear_o = 1'b1;
      repeat (25) @(posedge sys_clk_i);
      #1;
      fault_clear_o = 1'b0;
   endtask : clear_faults
endmodule : pmsl_host_model
`default_nettype wire

// ===== test/pmsl_speed_loop_tb_top.sv
// Testbench top: host model, PWM tick source and directed checks.
// Assumes the checker binds itself to the design from its own file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin compares++; if ((a) !== (e)) begin n_mismatch++; $display("BAD %0t %s", $time, m); end end
module pmsl_speed_loop_tb_top;
   logic sys_clk = 1'b0, rst_b = 1'b0, pwm_tick = 1'b0, dir, fclr, hov = 1'b0, huv = 1'b0, kill = 1'b0;
   logic [13:0] tgt;
   logic [7:0] mspd, crit = 8'd220, ovl = 8'd200, uvl = 8'd100;
   logic [14:0] acc = 15'd1000, dec = 15'd1000, ki = 15'h0;
   logic [11:0] mlim = 12'd2000, rlim = 12'd2000, modc = 12'h0, vqfix = 12'h123, bus = 12'd2000;
   logic [11:0] du = 12'h0, dv = 12'h0, dw = 12'h0, car = 12'h0, vq;
   logic signed [15:0] rotor = 16'sh0, sref, sfb;
   logic signed [12:0] vd = 13'sh0, trq;
   logic [3:0] fw;
   logic ovf, uvf, crf, ovt, uvt, crt;
   logic [2:0] gh, gl;
   int compares = 0, n_mismatch = 0, cnt = 0;
   int ramp_exp[7] = '{-23, -38, -53, -68, -38, -8, 0};
   // ------------------------------
   // Clock, tick and instances
   // ------------------------------
   always #2.5 sys_clk = ~sys_clk;
   // One-cycle tick every 20 clocks, restarted by reset
   always @(posedge sys_clk) begin
      #1;
      cnt = rst_b ? (cnt + 1) % 20 : 0;
      pwm_tick = (cnt == 19);
   end
   pmsl_host_model host (.sys_clk_i(sys_clk), .speed_target_o(tgt), .rotation_direction_o(dir),
      .min_speed_o(mspd), .fault_clear_o(fclr));
   pmsl_speed_loop DUT (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .pwm_tick_i(pwm_tick), .speed_target_i(tgt),
      .rotation_direction_i(dir), .min_speed_i(mspd), .accel_step_i(acc), .decel_step_i(dec),
      .ramp_shift_i(5'h1), .prop_gain_i(15'h1000), .integ_gain_i(ki), .motor_limit_i(mlim),
      .regen_limit_i(rlim), .rotor_freq_i(rotor), .speed_scale_i(16'h2000), .modulation_ceiling_i(modc),
      .vq_filter_shift_i(4'h1), .q_voltage_fixed_i(vqfix), .vd_i(vd), .bus_voltage_counts_i(bus),
      .critical_level_i(crit), .ov_level_i(ovl), .uv_level_i(uvl), .fault_clear_i(fclr),
      .hw_ov_disable_i(hov), .hw_uv_disable_i(huv), .gate_shutdown_input_i(kill), .duty_u_i(du),
      .duty_v_i(dv), .duty_w_i(dw), .carrier_i(car), .speed_reference_o(sref), .speed_feedback_o(sfb),
      .torque_command_o(trq), .q_voltage_ceiling_o(vq), .fault_word_o(fw), .overvoltage_flag_o(ovf),
      .undervoltage_flag_o(uvf), .bus_critical_flag_o(crf), .ov_trip_o(ovt), .uv_trip_o(uvt),
      .crit_trip_o(crt), .gate_high_o(gh), .gate_low_o(gl));
   // ------------------------------
   // Helpers
   // ------------------------------
   // Returns just after the n-th tick edge
   task automatic tk(input int n);
      repeat (n) begin
         do @(posedge sys_clk); while (pwm_tick !== 1'b1);
      end
      #1;
   endtask : tk
   task automatic wc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : wc
   task automatic results();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results
   // Watchdog at about thirty times the expected run
   initial begin
      #100000;
      n_mismatch++;
      results();
   end
   // ------------------------------
   // Test sequence
   // ------------------------------
   initial begin
      repeat (16) @(posedge sys_clk);
      #1 rst_b = 1'b1;
      wc(1);
      `CHK(fw, 4'h0, "reset faults")
      `CHK(sref, 16'sh0, "reset reference")
      $display("test reset done");
      // Floor and sign, then ramp away from zero and back to a stop
      host.set_speed(14'd5, 1'b0, 8'd1);
      tk(1);
      `CHK(sref, -16'sd8, "min speed sign")
      acc = 15'd30;
      dec = 15'd60;
      host.set_speed(14'd100, 1'b0, 8'd1);
      foreach (ramp_exp[i]) begin
         if (i == 4) host.set_speed(14'd0, 1'b0, 8'd1);
         tk(1);
         `CHK(sref, 16'(ramp_exp[i]), "ramp step")
      end
      acc = 15'd1000;
      host.set_speed(14'd100, 1'b1, 8'd1);
      tk(1);
      `CHK(sref, 16'sd100, "positive direction")
      $display("test ramp done");
      // Feedback scaling and regulator clamp both ways
      rotor = 16'sd1000;
      rlim = 12'd300;
      tk(1);
      `CHK(sfb, 16'sd500, "feedback scale")
      tk(1);
      `CHK(trq, -13'sd300, "regen clamp")
      rotor = -16'sd1000;
      mlim = 12'd200;
      tk(2);
      `CHK(sfb, -16'sd500, "negative feedback")
      `CHK(trq, 13'sd200, "motor clamp")
      mlim = 12'd2000;
      tk(1);
      `CHK(trq, 13'sd600, "error sign")
      ki = 15'h1000;
      tk(4);
      `CHK(trq, 13'sd2000, "clamp with integrator")
      rotor = 16'sd200;
      tk(2);
      `CHK(trq, 13'sd1800, "integrator held in clamp")
      ki = 15'h0;
      $display("test regulator done");
      // Fixed then dynamic q voltage ceiling
      tk(1);
      wc(15);
      `CHK(vq, 12'h123, "fixed ceiling")
      modc = 12'd1000;
      vd = -13'sd600;
      tk(1);
      wc(15);
      `CHK(vq, 12'd545, "dynamic ceiling")
      $display("test vq done");
      // Software and hardware bus trips, latching and clear
      bus = 12'd3300;
      tk(1);
      `CHK({ovt, ovf, fw}, 6'h31, "software over")
      bus = 12'd3400;
      wc(2);
      `CHK(fw, 4'h3, "hardware over")
      bus = 12'd2000;
      tk(1);
      `CHK({ovt, ovf}, 2'b01, "over latched")
      host.clear_faults();
      `CHK({ovf, fw}, 5'h0, "cleared")
      bus = 12'd900;
      tk(1);
      `CHK({uvt, uvf, fw}, 6'h35, "under trips")
      bus = 12'd2000;
      huv = 1'b1;
      host.clear_faults();
      uvl = 8'h0;
      bus = 12'd900;
      tk(1);
      `CHK(fw, 4'h0, "hw under disabled")
      bus = 12'd2000;
      uvl = 8'd100;
      $display("test bus faults done");
      // Gate run, shutdown pin, then critical zero vector
      du = 12'd100;
      dv = 12'd10;
      dw = 12'd100;
      car = 12'd50;
      wc(2);
      `CHK({gh, gl}, 6'b101010, "run gates")
      kill = 1'b1;
      wc(4);
      `CHK({gh, gl}, 6'h0, "shutdown gates")
      crit = 8'd100;
      tk(1);
      `CHK({crt, crf, fw[3], gh, gl}, 9'h1c7, "critical zero vector")
      $display("test gates done");
      results();
   end
endmodule : pmsl_speed_loop_tb_top
`default_nettype wire
